// file: rtl/ccs_pkg.sv
package ccs_pkg;

    // ========================================================
    // Fuse defaults and encodings
    // ========================================================
    // Fuse storage: 1 is unprogrammed, 0 is programmed
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_DELIVERED = 4'h1;
    localparam logic [1:0] SUT_DELIVERED = 2'h2;
    localparam logic OSCILLATOR_OPTION_FUSE_DELIVERED = 1'b1;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN = 4'hA;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LFXTAL = 4'h9;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXTRC_MIN = 4'h5;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN = 4'h1;
    localparam logic [2:0] XTAL_RANGE_LOW = 3'h5;
    localparam logic [2:0] XTAL_RANGE_MID = 3'h6;

    // ========================================================
    // Start-up counts, in cycles of the counted oscillator; fuse settle in mclk cycles
    // ========================================================
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] WDT_SHORT_CYCLES = 17'h01000;
    localparam logic [CNT_W-1:0] WDT_LONG_CYCLES = 17'h10000;
    localparam logic [CNT_W-1:0] START_258 = 17'h00102;
    localparam logic [CNT_W-1:0] START_1K = 17'h00400;
    localparam logic [CNT_W-1:0] START_16K = 17'h04000;
    localparam logic [CNT_W-1:0] START_32K = 17'h08000;
    localparam logic [CNT_W-1:0] START_18 = 17'h00012;
    localparam logic [CNT_W-1:0] START_6 = 17'h00006;
    localparam logic [1:0] FUSE_SETTLE_CYCLES = 2'h2;

    // ========================================================
    // Register map
    // ========================================================
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] FUSE_ADDR = 12'h008;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ADC_BIT = 2;
    localparam int CTRL_ASYNC_BIT = 3;
    localparam int CTRL_GO_BIT = 4;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
    localparam logic CTRL_ADC_RESET = 1'b0;
    localparam logic CTRL_ASYNC_RESET = 1'b0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_RANGE_LSB = 8;
    localparam int STAT_SWING_BIT = 10;
    localparam int STAT_CLK_LSB = 11;
    localparam int STAT_FROM_RST_BIT = 16;
    localparam int FUSE_CLOCK_SOURCE_SELECT_FUSES_LSB = 0;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_OSCILLATOR_OPTION_FUSE_BIT = 6;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [2:0] {
        SRC_XTAL, SRC_LFXTAL, SRC_EXTRC, SRC_INTRC, SRC_EXTCLK
    } ccs_src_t;
    typedef enum logic [1:0] {DLY_NONE, DLY_SHORT, DLY_LONG} ccs_delay_t;
    typedef enum logic [1:0] {
        SLP_IDLE, SLP_ADC_NR, SLP_PDOWN, SLP_PSAVE
    } ccs_sleep_t;
    typedef enum logic [2:0] {
        ST_LOAD, ST_RESET_DELAY, ST_START, ST_RUN, ST_SLEEP
    } ccs_state_t;
    typedef struct packed {
        logic [CNT_W-1:0] cycles;
        ccs_delay_t delay;
    } ccs_startup_t;
    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic oscillator_option_fuse;
    } ccs_fuse_t;
    typedef struct packed {
        logic core;
        logic periph;
        logic flash;
        logic async_tmr;
        logic conv;
    } ccs_clk_en_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ccs_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ccs_apb_rsp_t;

endpackage

// file: rtl/ccs_clock_control.sv
module ccs_clock_control
    import ccs_pkg::*;
#(
    parameter logic [CNT_W-1:0] WDT_SHORT = WDT_SHORT_CYCLES,
    parameter logic [CNT_W-1:0] WDT_LONG = WDT_LONG_CYCLES,
    parameter logic [CNT_W-1:0] START_XTAL_LONG = START_16K,
    parameter logic [CNT_W-1:0] START_LF_LONG = START_32K
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ccs_apb_req_t apb_req,
    output ccs_apb_rsp_t apb_rsp,
    input wire ccs_fuse_t fuse_pins,
    input wire logic source_osc_in,
    input wire logic watchdog_osc_in,
    input wire logic wake_periph_irq,
    input wire logic wake_async_irq,
    input wire logic twi_addr_match,
    output ccs_clk_en_t clk_en,
    output ccs_src_t osc_source,
    output logic [1:0] crystal_range,
    output logic amp_full_swing,
    output logic cpu_reset,
    output logic cpu_hold,
    output logic async_detect_en
);

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        ccs_fuse_t fuse_s1;
        ccs_fuse_t fuse_s2;
        logic [1:0] osc_prev;
        ccs_fuse_t fuse;
        ccs_state_t state;
        ccs_sleep_t sleep_mode;
        logic from_reset;
        logic [CNT_W-1:0] cnt;
        logic [1:0] settle;
        logic adc_en;
        logic async_en;
        ccs_clk_en_t clk_en;
        logic [31:0] prdata;
    } ccs_regs_t;

    localparam ccs_fuse_t FUSE_RESET = '{
        clock_source_select_fuses: CLOCK_SOURCE_SELECT_FUSES_DELIVERED, startup_time_fuses: SUT_DELIVERED, oscillator_option_fuse: OSCILLATOR_OPTION_FUSE_DELIVERED
    };

    ccs_regs_t s;
    ccs_regs_t next_s;

    // ========================================================
    // Decoders
    // ========================================================
    function automatic ccs_src_t decode_source(input logic [3:0] clock_source_select_fuses);
        if (clock_source_select_fuses >= CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) begin
            return SRC_XTAL;
        end else if (clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_LFXTAL) begin
            return SRC_LFXTAL;
        end else if (clock_source_select_fuses >= CLOCK_SOURCE_SELECT_FUSES_EXTRC_MIN) begin
            return SRC_EXTRC;
        end else if (clock_source_select_fuses >= CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN) begin
            return SRC_INTRC;
        end
        return SRC_EXTCLK;
    endfunction

    function automatic ccs_startup_t decode_startup(input ccs_fuse_t f);
        ccs_startup_t r;
        r = '{cycles: START_6, delay: DLY_LONG};
        unique case (decode_source(f.clock_source_select_fuses))
            SRC_XTAL: begin
                unique case ({f.clock_source_select_fuses[0], f.startup_time_fuses})
                    3'h0: r = '{cycles: START_258, delay: DLY_SHORT};
                    3'h1: r = '{cycles: START_258, delay: DLY_LONG};
                    3'h2: r = '{cycles: START_1K, delay: DLY_NONE};
                    3'h3: r = '{cycles: START_1K, delay: DLY_SHORT};
                    3'h4: r = '{cycles: START_1K, delay: DLY_LONG};
                    3'h5: r = '{cycles: START_XTAL_LONG, delay: DLY_NONE};
                    3'h6: r = '{cycles: START_XTAL_LONG, delay: DLY_SHORT};
                    3'h7: r = '{cycles: START_XTAL_LONG, delay: DLY_LONG};
                endcase
            end
            SRC_LFXTAL: begin
                unique case (f.startup_time_fuses)
                    2'h0: r = '{cycles: START_1K, delay: DLY_SHORT};
                    2'h1: r = '{cycles: START_1K, delay: DLY_LONG};
                    // Reserved code 11 falls back to the safest choice
                    default: r = '{cycles: START_LF_LONG, delay: DLY_LONG};
                endcase
            end
            SRC_EXTRC: begin
                unique case (f.startup_time_fuses)
                    2'h0: r = '{cycles: START_18, delay: DLY_NONE};
                    2'h1: r = '{cycles: START_18, delay: DLY_SHORT};
                    2'h2: r = '{cycles: START_18, delay: DLY_LONG};
                    2'h3: r = '{cycles: START_6, delay: DLY_SHORT};
                endcase
            end
            SRC_INTRC, SRC_EXTCLK: begin
                unique case (f.startup_time_fuses)
                    2'h0: r = '{cycles: START_6, delay: DLY_NONE};
                    2'h1: r = '{cycles: START_6, delay: DLY_SHORT};
                    default: r = '{cycles: START_6, delay: DLY_LONG};
                endcase
            end
        endcase
        return r;
    endfunction

    function automatic logic [1:0] decode_range(input ccs_fuse_t f);
        // Wide range whenever the option fuse is programmed
        if (f.oscillator_option_fuse == FUSE_PROGRAMMED) begin
            return 2'h3;
        end else if (f.clock_source_select_fuses[3:1] == XTAL_RANGE_LOW) begin
            return 2'h0;
        end else if (f.clock_source_select_fuses[3:1] == XTAL_RANGE_MID) begin
            return 2'h1;
        end
        return 2'h2;
    endfunction

    function automatic ccs_clk_en_t gate_for(
        input ccs_state_t st,
        input ccs_sleep_t mode,
        input logic adc_on,
        input logic async_on
    );
        ccs_clk_en_t g;
        g = '0;
        if (st == ST_RUN) begin
            g = '{core: 1'b1, periph: 1'b1, flash: 1'b1,
                  async_tmr: async_on, conv: adc_on};
        end else if (st == ST_SLEEP) begin
            // Core off in every sleep mode stops all computation
            g.core = 1'b0;
            g.periph = (mode == SLP_IDLE);
            g.async_tmr = async_on && (mode != SLP_PDOWN);
            g.conv = adc_on && (mode == SLP_IDLE || mode == SLP_ADC_NR);
        end
        g.flash = g.core;
        return g;
    endfunction

    function automatic logic [31:0] read_value(
        input ccs_regs_t r,
        input logic [11:0] addr
    );
        logic [31:0] v;
        v = '0;
        unique case (addr)
            CTRL_ADDR: begin
                v[CTRL_MODE_LSB +: 2] = r.sleep_mode;
                v[CTRL_ADC_BIT] = r.adc_en;
                v[CTRL_ASYNC_BIT] = r.async_en;
            end
            STATUS_ADDR: begin
                v[STAT_STATE_LSB +: 3] = r.state;
                v[STAT_SRC_LSB +: 3] = decode_source(r.fuse.clock_source_select_fuses);
                v[STAT_RANGE_LSB +: 2] = decode_range(r.fuse);
                v[STAT_SWING_BIT] = (r.fuse.oscillator_option_fuse == FUSE_PROGRAMMED);
                v[STAT_CLK_LSB +: 5] = r.clk_en;
                v[STAT_FROM_RST_BIT] = r.from_reset;
            end
            FUSE_ADDR: begin
                v[FUSE_CLOCK_SOURCE_SELECT_FUSES_LSB +: 4] = r.fuse.clock_source_select_fuses;
                v[FUSE_SUT_LSB +: 2] = r.fuse.startup_time_fuses;
                v[FUSE_OSCILLATOR_OPTION_FUSE_BIT] = r.fuse.oscillator_option_fuse;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    function automatic logic addr_mapped(input logic [11:0] addr);
        return addr == CTRL_ADDR || addr == STATUS_ADDR ||
            addr == FUSE_ADDR;
    endfunction

    // ========================================================
    // Next state
    // ========================================================
    always_comb begin
        logic osc_edge;
        logic wdt_edge;
        logic wake;
        logic wr_ctrl;
        ccs_startup_t su;
        logic [CNT_W-1:0] limit;
        osc_edge = 1'b0;
        wdt_edge = 1'b0;
        wake = 1'b0;
        wr_ctrl = 1'b0;
        su = decode_startup(s.fuse);
        limit = '0;
        next_s = s;

        // Pins from other domains pass two flops before use
        next_s.pin_s1 = {twi_addr_match, wake_async_irq, wake_periph_irq,
                         watchdog_osc_in, source_osc_in};
        next_s.pin_s2 = s.pin_s1;
        next_s.fuse_s1 = fuse_pins;
        next_s.fuse_s2 = s.fuse_s1;
        next_s.osc_prev = s.pin_s2[1:0];
        osc_edge = s.pin_s2[0] && !s.osc_prev[0];
        wdt_edge = s.pin_s2[1] && !s.osc_prev[1];
        // Async wakes work in any mode; clocked ones need the periph clock
        wake = s.pin_s2[3] || s.pin_s2[4] ||
            (s.pin_s2[2] && s.clk_en.periph);

        wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite &&
            apb_req.paddr == CTRL_ADDR;
        if (wr_ctrl) begin
            next_s.adc_en = apb_req.pwdata[CTRL_ADC_BIT];
            next_s.async_en = apb_req.pwdata[CTRL_ASYNC_BIT];
            next_s.sleep_mode = ccs_sleep_t'(
                apb_req.pwdata[CTRL_MODE_LSB +: 2]);
        end

        unique case (s.state)
            ST_LOAD: begin
                // Fuse pins need two cycles to settle through the flops
                if (s.settle == FUSE_SETTLE_CYCLES) begin
                    next_s.fuse = s.fuse_s2;
                    next_s.cnt = '0;
                    if (decode_startup(s.fuse_s2).delay == DLY_NONE) begin
                        next_s.state = ST_START;
                    end else begin
                        next_s.state = ST_RESET_DELAY;
                    end
                end else begin
                    next_s.settle = s.settle + 2'h1;
                end
            end
            ST_RESET_DELAY: begin
                limit = (su.delay == DLY_LONG) ? WDT_LONG : WDT_SHORT;
                if (wdt_edge) begin
                    if (s.cnt + 1'b1 >= limit) begin
                        next_s.cnt = '0;
                        next_s.state = ST_START;
                    end else begin
                        next_s.cnt = s.cnt + 1'b1;
                    end
                end
            end
            ST_START: begin
                if (osc_edge) begin
                    if (s.cnt + 1'b1 >= su.cycles) begin
                        next_s.cnt = '0;
                        next_s.from_reset = 1'b0;
                        next_s.state = ST_RUN;
                    end else begin
                        next_s.cnt = s.cnt + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (wr_ctrl && apb_req.pwdata[CTRL_GO_BIT]) begin
                    next_s.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    next_s.cnt = '0;
                    // Deep sleep stopped the oscillator, so re-time it
                    if (s.sleep_mode == SLP_PDOWN ||
                        s.sleep_mode == SLP_PSAVE) begin
                        next_s.state = ST_START;
                    end else begin
                        next_s.state = ST_RUN;
                    end
                end
            end
        endcase

        next_s.clk_en = gate_for(next_s.state, next_s.sleep_mode,
                                 next_s.adc_en, next_s.async_en);

        // Read data captured in the setup phase, shown in the access phase
        if (apb_req.psel && !apb_req.penable) begin
            next_s.prdata = read_value(s, apb_req.paddr);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{
                pin_s1: '0, pin_s2: '0,
                fuse_s1: FUSE_RESET, fuse_s2: FUSE_RESET,
                osc_prev: '0, fuse: FUSE_RESET,
                state: ST_LOAD, sleep_mode: ccs_sleep_t'(CTRL_MODE_RESET),
                from_reset: 1'b1, cnt: '0, settle: '0,
                adc_en: CTRL_ADC_RESET, async_en: CTRL_ASYNC_RESET,
                clk_en: '0, prdata: '0
            };
        end else begin
            s <= next_s;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign apb_rsp = '{
        prdata: s.prdata,
        pready: apb_req.psel && apb_req.penable,
        pslverr: apb_req.psel && apb_req.penable &&
            !addr_mapped(apb_req.paddr)
    };
    assign clk_en = s.clk_en;
    assign osc_source = decode_source(s.fuse.clock_source_select_fuses);
    assign crystal_range = decode_range(s.fuse);
    assign amp_full_swing = (s.fuse.oscillator_option_fuse == FUSE_PROGRAMMED);
    assign cpu_reset = s.from_reset;
    assign cpu_hold = (s.state != ST_RUN);
    assign async_detect_en = !s.clk_en.periph;

endmodule

// file: verification/ccs_clock_control_assertions.sv
module ccs_clock_control_checker
    import ccs_pkg::*;
#(
    parameter logic [CNT_W-1:0] WDT_SHORT = WDT_SHORT_CYCLES,
    parameter logic [CNT_W-1:0] WDT_LONG = WDT_LONG_CYCLES,
    parameter logic [CNT_W-1:0] START_XTAL_LONG = START_16K,
    parameter logic [CNT_W-1:0] START_LF_LONG = START_32K
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ccs_apb_req_t apb_req,
    input wire ccs_apb_rsp_t apb_rsp,
    input wire ccs_fuse_t fuse_pins,
    input wire logic source_osc_in,
    input wire logic watchdog_osc_in,
    input wire logic wake_periph_irq,
    input wire logic wake_async_irq,
    input wire logic twi_addr_match,
    input wire ccs_clk_en_t clk_en,
    input wire ccs_src_t osc_source,
    input wire logic [1:0] crystal_range,
    input wire logic amp_full_swing,
    input wire logic cpu_reset,
    input wire logic cpu_hold,
    input wire logic async_detect_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    function automatic ccs_src_t exp_src(logic [3:0] c);
        if (c >= CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) return SRC_XTAL;
        if (c == CLOCK_SOURCE_SELECT_FUSES_LFXTAL) return SRC_LFXTAL;
        if (c >= CLOCK_SOURCE_SELECT_FUSES_EXTRC_MIN) return SRC_EXTRC;
        if (c >= CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN) return SRC_INTRC;
        return SRC_EXTCLK;
    endfunction

    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic unmapped = acc && apb_req.paddr != CTRL_ADDR
        && apb_req.paddr != STATUS_ADDR && apb_req.paddr != FUSE_ADDR;

    // ========================================================
    // Properties
    // ========================================================
    sequence s_idle_sleep;
        !clk_en.core && clk_en.periph;
    endsequence
    sequence s_boot_done;
        !cpu_hold && clk_en.core;
    endsequence

    a_unmapped_error: assert property (unmapped |->
        apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access without error");
    a_source_decode: assert property (!cpu_reset |->
        osc_source == exp_src(fuse_pins.clock_source_select_fuses))
        else $error("clock source decode wrong");
    a_range_decode: assert property (
        !cpu_reset && osc_source == SRC_XTAL |-> crystal_range ==
        (fuse_pins.oscillator_option_fuse ? 2'(fuse_pins.clock_source_select_fuses[3:1] - 3'h5) : 2'h3))
        else $error("crystal range wrong");
    a_swing_option: assert property (
        !cpu_reset |-> amp_full_swing == !fuse_pins.oscillator_option_fuse)
        else $error("amplifier swing wrong");
    a_flash_follows: assert property (clk_en.flash == clk_en.core)
        else $error("program memory clock differs from core");
    a_core_hold: assert property (!clk_en.core |-> cpu_hold)
        else $error("core clock off while running");
    a_async_detect: assert property (
        async_detect_en == !clk_en.periph)
        else $error("async detect not tied to peripheral clock");
    a_reset_min: assert property ($fell(sys_rst) |-> cpu_reset [*8])
        else $error("internal reset released too early");
    a_reset_release: assert property ($fell(cpu_reset) |-> s_boot_done)
        else $error("reset release without core start");
    a_wake_idle: assert property (
        s_idle_sleep ##0 wake_periph_irq |-> ##[1:4] !cpu_hold)
        else $error("idle wake too slow");
    a_delivered_src: assert property (@(posedge mclk) disable iff (1'b0)
        sys_rst |-> osc_source == SRC_INTRC && clk_en == 5'h00)
        else $error("reset source or enables wrong");
endmodule

bind ccs_clock_control ccs_clock_control_checker #(
    .WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG),
    .START_XTAL_LONG(START_XTAL_LONG), .START_LF_LONG(START_LF_LONG)
) chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fuse_pins(fuse_pins), .source_osc_in(source_osc_in),
    .watchdog_osc_in(watchdog_osc_in), .wake_periph_irq(wake_periph_irq),
    .wake_async_irq(wake_async_irq), .twi_addr_match(twi_addr_match),
    .clk_en(clk_en), .osc_source(osc_source),
    .crystal_range(crystal_range), .amp_full_swing(amp_full_swing),
    .cpu_reset(cpu_reset), .cpu_hold(cpu_hold),
    .async_detect_en(async_detect_en)
);

// file: verification/ccs_osc_model.sv
module ccs_osc_model (
    input wire logic mclk,
    input wire logic slow,
    output logic src_osc,
    output logic wdt_osc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] sc = 3'h0;
    logic wc = 1'b0;
    // Free-running; slow mode halves the source rate to expose counting
    initial src_osc = 1'b0;
    initial wdt_osc = 1'b0;
    always @(posedge mclk) begin
        if (sc >= (slow ? 3'h3 : 3'h1)) begin
            sc <= 3'h0;
            src_osc <= !src_osc;
        end else begin
            sc <= sc + 3'h1;
        end
        wc <= !wc;
        if (wc) begin
            wdt_osc <= !wdt_osc;
        end
    end
endmodule

// file: verification/clock_source_startup_control_bench.sv
module clock_source_startup_control_bench
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        ccs_fuse_t f;
        ccs_src_t src;
        logic [1:0] rng;
        logic [15:0] edges;
    } ccs_row_t;
    // Code 101 rows stand for a ceramic resonator
    ccs_row_t rows [12] = '{
        '{'{4'hA, 2'h0, 1'b1}, SRC_XTAL, 2'h0, 16'h010A},
        '{'{4'hC, 2'h1, 1'b1}, SRC_XTAL, 2'h1, 16'h0112},
        '{'{4'hE, 2'h2, 1'b1}, SRC_XTAL, 2'h2, 16'h0400},
        '{'{4'hA, 2'h3, 1'b0}, SRC_XTAL, 2'h3, 16'h0408},
        '{'{4'hB, 2'h0, 1'b1}, SRC_XTAL, 2'h0, 16'h0410},
        '{'{4'hD, 2'h1, 1'b1}, SRC_XTAL, 2'h1, 16'h000C},
        '{'{4'hF, 2'h2, 1'b1}, SRC_XTAL, 2'h2, 16'h0014},
        '{'{4'h9, 2'h2, 1'b1}, SRC_LFXTAL, 2'h0, 16'h0024},
        '{'{4'h5, 2'h3, 1'b1}, SRC_EXTRC, 2'h0, 16'h000E},
        '{'{4'h1, 2'h2, 1'b1}, SRC_INTRC, 2'h0, 16'h0016},
        '{'{4'h0, 2'h0, 1'b1}, SRC_EXTCLK, 2'h0, 16'h0006},
        '{'{4'hF, 2'h3, 1'b0}, SRC_XTAL, 2'h3, 16'h001C}};
    logic mclk, sys_rst, slow, src_osc, wdt_osc, wk_p, wk_a, two_wire_serial_port;
    logic swing, cpu_reset, cpu_hold, adet, e;
    ccs_apb_req_t req;
    ccs_apb_rsp_t rsp;
    ccs_fuse_t fuse;
    ccs_clk_en_t clk_en;
    ccs_src_t src;
    logic [1:0] rng;
    logic [31:0] q, st, m;
    int err_total, checks, cyc;

    ccs_osc_model osc_u (.mclk(mclk), .slow(slow), .src_osc(src_osc),
        .wdt_osc(wdt_osc));
    ccs_clock_control #(.WDT_SHORT(17'h00008), .WDT_LONG(17'h00010),
        .START_XTAL_LONG(17'h0000C), .START_LF_LONG(17'h00014)) dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .fuse_pins(fuse), .source_osc_in(src_osc),
        .watchdog_osc_in(wdt_osc), .wake_periph_irq(wk_p),
        .wake_async_irq(wk_a), .twi_addr_match(two_wire_serial_port), .clk_en(clk_en),
        .osc_source(src), .crystal_range(rng), .amp_full_swing(swing),
        .cpu_reset(cpu_reset), .cpu_hold(cpu_hold),
        .async_detect_en(adet));

    // ========================================================
    // Tasks
    // ========================================================
    task automatic summarize();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 16) begin
            err_total++;
            summarize();
        end
    endtask
    // Cycles until the core is released, counted from here
    task automatic wait_run();
        cyc = 0;
        while (cpu_hold !== 1'b0 && cyc < 30000) begin
            @(posedge mclk);
            cyc++;
        end
        if (cyc >= 30000) begin
            err_total++;
            summarize();
        end
    endtask
    // Edge counts are exact; slack covers oscillator phase and sync
    task automatic near(int n);
        check(32'(cyc >= 4 * n - 8 && cyc <= 4 * n + 16), 32'h1);
    endtask
    task automatic boot(ccs_fuse_t f);
        @(posedge mclk);
        fuse <= f;
        sys_rst <= 1'b1;
        repeat (8) @(posedge mclk);
        check(32'(src), 32'(SRC_INTRC));
        check(32'({clk_en, cpu_reset, cpu_hold}), 32'h3);
        sys_rst <= 1'b0;
        wait_run();
    endtask
    task automatic sleep(logic [31:0] ctrl, logic [4:0] en);
        apb(1'b1, CTRL_ADDR, ctrl);
        @(posedge mclk);
        check(32'(clk_en), 32'(en));
        check(32'(cpu_hold), 32'h1);
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        {sys_rst, slow, wk_p, wk_a, two_wire_serial_port} = 5'h10;
        req = '0;
        fuse = '{CLOCK_SOURCE_SELECT_FUSES_DELIVERED, SUT_DELIVERED, OSCILLATOR_OPTION_FUSE_DELIVERED};
        err_total = 0;
        checks = 0;
        for (int i = 0; i < 12; i++) begin
            boot(rows[i].f);
            near(int'(rows[i].edges));
            check(32'(cpu_reset), 32'h0);
            check(32'(adet), 32'h0);
            check(32'(src), 32'(rows[i].src));
            if (rows[i].src == SRC_XTAL) check(32'(rng), 32'(rows[i].rng));
            check(32'(swing), 32'(!rows[i].f.oscillator_option_fuse));
            apb(1'b0, FUSE_ADDR, 32'h0);
            check(q, 32'({rows[i].f.oscillator_option_fuse, rows[i].f.startup_time_fuses, rows[i].f.clock_source_select_fuses}));
            apb(1'b0, STATUS_ADDR, 32'h0);
            st = {16'h0, 5'h1C, !rows[i].f.oscillator_option_fuse, rows[i].rng, 1'b0,
                rows[i].src, 4'h3};
            m = rows[i].src == SRC_XTAL ? 32'h0000FFFF : 32'h0000FCFF;
            check(q & m, st & m);
        end
        apb(1'b1, CTRL_ADDR, 32'h0000000C);
        apb(1'b0, CTRL_ADDR, 32'h0);
        check(q, 32'h0000000C);
        @(posedge mclk);
        check(32'(clk_en), 32'h1F);
        sleep(32'h1C, 5'h0B);
        wk_p <= 1'b1;
        wait_run();
        wk_p <= 1'b0;
        check(32'(cyc <= 4), 32'h1);
        sleep(32'h1D, 5'h03);
        check(32'(adet), 32'h1);
        two_wire_serial_port <= 1'b1;
        wait_run();
        two_wire_serial_port <= 1'b0;
        check(32'(cyc <= 4), 32'h1);
        sleep(32'h12, 5'h00);
        wk_p <= 1'b1;
        repeat (20) @(posedge mclk);
        check(32'(cpu_hold), 32'h1);
        wk_p <= 1'b0;
        wk_a <= 1'b1;
        wait_run();
        wk_a <= 1'b0;
        near(12);
        slow <= 1'b1;
        sleep(32'h1B, 5'h02);
        wk_a <= 1'b1;
        wait_run();
        wk_a <= 1'b0;
        slow <= 1'b0;
        near(24);
        apb(1'b0, 12'h00C, 32'h0);
        check(32'({q, e}), 32'h1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        st = q;
        apb(1'b1, STATUS_ADDR, 32'hFFFFFFFF);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(q, st);
        summarize();
    end
endmodule
